/* File: hdl/dbx_core.sv */
`timescale 1ns/1ps
// Operation
// R1: Only four and eight beat bursts
// R2: Main register A3 picks burst order
// R3: Four-beat order: add or XOR start
// R4: Eight sequential: nibble wrap, then flip A2
// R5: Eight interleaved: start XOR beat
// R6: Back-to-back bursts leave no gap
// R7: Controller never cuts four-beat bursts
// R8: Eight-beat: only same-direction interruption
// R9: No burst-terminate command exists
// R10: Load-mode with bank one writes extension
// R11: Controller writes only when precharged, clock-enabled
// R12: Controller waits config write cycle time
// R13: Extension undefined until programmed
// R14: Self refresh turns loop off, on
// R15: Controller waits 200 cycles before read
// R16: A0 zero enables the delay loop
// R17: A1 selects full or reduced drive
// R18: A5..A3 added latency, 111 reserved
// R19: A6,A2 pick termination setting
// R20: A11 read strobe copy, A10 floats complement
// R21: A9..A7 calibration exit or default
// R22: Controller rounds write recovery up
// R23: A12 disables all output buffers
// R24: Controller keeps read strobe off on x16
// R25: Controller avoids reserved latency, calibration codes; the bench still loads them to probe the flags
module dbx_core (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Command bus from controller
  input wire dbx_pkg::dbx_cmd_t cmd,
  input wire logic cke,
  // Beat output
  output dbx_pkg::dbx_beat_t beat_out,
  // Decoded configuration
  output dbx_pkg::dbx_ext_cfg_t ext_cfg,
  output logic ext_valid,
  output logic dll_running,
  output logic seq_interleaved,
  output logic [3:0] burst_beat_count,
  output logic bl_bad
);
  import dbx_pkg::*;

  // ********************************************************************
  // Command decode
  // ********************************************************************
  logic [2:0] code;
  logic is_load;
  logic is_rd;
  logic is_wr;
  logic sr_entry;
  logic sr_exit;
  logic cke_prev_q;
  assign code = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  assign is_load = cke && !cmd.cs_n && code == CMD_LOAD_MODE;
  assign is_rd = cke && !cmd.cs_n && code == CMD_READ;
  assign is_wr = cke && !cmd.cs_n && code == CMD_WRITE;
  // Refresh code with clock enable dropping enters self refresh
  assign sr_entry = cke_prev_q && !cke && !cmd.cs_n &&
                    code == CMD_REFRESH;
  assign sr_exit = !cke_prev_q && cke;

  // Previous clock enable; resets to the pin's idle high level so that
  // the first edge after reset does not look like a self refresh exit
  always_ff @(posedge clk) begin
    if (rst) begin
      cke_prev_q <= 1'b1;
    end else if (ce) begin
      cke_prev_q <= cke;
    end
  end

  // ********************************************************************
  // Main register burst fields
  // ********************************************************************
  logic [3:0] bl_q;
  logic bt_q;
  logic bl_bad_q;
  // Unknown length codes are flagged and the old length kept
  always_ff @(posedge clk) begin
    if (rst) begin
      bl_q <= BEATS_4;
      bt_q <= 1'b0;
      bl_bad_q <= 1'b0;
    end else if (ce && is_load && cmd.bank == BANK_MAIN) begin
      bt_q <= cmd.addr[MAIN_BT_BIT]; // R2
      if (cmd.addr[MAIN_BL_LSB +: 3] == BL_CODE_4) begin
        bl_q <= BEATS_4; // R1
        bl_bad_q <= 1'b0;
      end else if (cmd.addr[MAIN_BL_LSB +: 3] == BL_CODE_8) begin
        bl_q <= BEATS_8; // R1
        bl_bad_q <= 1'b0;
      end else begin
        bl_bad_q <= 1'b1; // R1
      end
    end
  end

  // ********************************************************************
  // First extended register
  // ********************************************************************
  logic [ROW_W-1:0] ext_q;
  logic ext_valid_q;
  // Only bank select one with a load command lands here
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_q <= '0;
      ext_valid_q <= 1'b0; // R13
    end else if (ce && is_load && cmd.bank == BANK_EXT_ONE) begin
      ext_q <= cmd.addr; // R10
      ext_valid_q <= 1'b1; // R13
    end
  end

  // Field decode, registered so the outputs come from flops
  dbx_ext_cfg_t cfg_d;
  dbx_ext_cfg_t cfg_q;
  always_comb begin
    cfg_d.dll_on = !ext_q[EXT_DLL_BIT]; // R16
    cfg_d.drive_reduced = ext_q[EXT_DRV_BIT]; // R17
    cfg_d.rtt = dbx_rtt_t'({ext_q[EXT_RTT_HI_BIT],
                            ext_q[EXT_RTT_LO_BIT]}); // R19
    cfg_d.added_latency = ext_q[EXT_AL_LSB +: 3]; // R18
    cfg_d.al_reserved = ext_q[EXT_AL_LSB +: 3] == AL_RESERVED; // R18
    cfg_d.cal_default = ext_q[EXT_CAL_LSB +: 3] == CAL_DEFAULT; // R21
    cfg_d.cal_reserved = ext_q[EXT_CAL_LSB +: 3] != CAL_DEFAULT &&
                         ext_q[EXT_CAL_LSB +: 3] != CAL_EXIT; // R21
    cfg_d.read_strobe_copy = ext_q[EXT_RSTB_BIT]; // R20
    cfg_d.strobe_n_float = ext_q[EXT_NSTB_BIT]; // R20
    cfg_d.outputs_off = ext_q[EXT_QOFF_BIT]; // R23
  end

  // Registered decode
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= '0;
    end else if (ce) begin
      cfg_q <= cfg_d;
    end
  end

  // ********************************************************************
  // Delay loop state
  // ********************************************************************
  logic in_sr_q;
  logic dll_q;
  // Self refresh gates the loop regardless of the enable bit
  always_ff @(posedge clk) begin
    if (rst) begin
      in_sr_q <= 1'b0;
    end else if (ce) begin
      if (sr_entry) begin
        in_sr_q <= 1'b1; // R14
      end else if (sr_exit) begin
        in_sr_q <= 1'b0; // R14
      end
    end
  end

  // Running loop follows enable bit once the extension is written, unless in self refresh
  always_ff @(posedge clk) begin
    if (rst) begin
      dll_q <= 1'b0;
    end else if (ce) begin
      dll_q <= ext_valid_q && cfg_d.dll_on && !in_sr_q &&
               !sr_entry; // R14 R16
    end
  end

  // ********************************************************************
  // Burst engine
  // ********************************************************************
  typedef enum logic {DBX_IDLE, DBX_BURST} dbx_state_t;
  dbx_state_t state_q;
  logic [3:0] cnt_q;
  logic [2:0] start_q;
  logic [COL_W-1:0] base_q;
  logic dir_wr_q;
  logic last;
  logic accept;
  logic [2:0] off;
  dbx_beat_t beat_q;

  assign last = cnt_q == bl_q - 4'h1;
  // New command taken when idle, at the last beat (seamless), or as a
  // same-direction interruption of an eight-beat burst. Any other
  // command during a burst does not stop it: there is no terminate.
  always_comb begin
    accept = 1'b0;
    if (is_rd || is_wr) begin
      if (state_q == DBX_IDLE || last) begin
        accept = 1'b1; // R6
      end else if (bl_q == BEATS_8 && dir_wr_q == is_wr) begin
        accept = 1'b1; // R8
      end
    end
  end

  // Burst state and counters
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= DBX_IDLE;
      cnt_q <= '0;
      start_q <= '0;
      base_q <= '0;
      dir_wr_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        DBX_IDLE: begin
          if (accept) begin
            state_q <= DBX_BURST;
          end
        end
        DBX_BURST: begin
          if (last && !accept) begin
            state_q <= DBX_IDLE; // R9
          end
        end
        default: state_q <= DBX_IDLE;
      endcase
      if (accept) begin
        cnt_q <= '0;
        start_q <= cmd.addr[2:0];
        base_q <= cmd.addr[COL_W-1:0];
        dir_wr_q <= is_wr;
      end else if (state_q == DBX_BURST) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  dbx_order u_order (
    .start(start_q),
    .interleaved(bt_q),
    .eight(bl_q == BEATS_8),
    .beat(cnt_q[2:0]),
    .offset(off)
  );

  // Beat output register
  always_ff @(posedge clk) begin
    if (rst) begin
      beat_q <= '0;
    end else if (ce) begin
      beat_q.valid <= state_q == DBX_BURST;
      beat_q.is_write <= dir_wr_q;
      beat_q.col <= {base_q[COL_W-1:3], off}; // R3 R4 R5
    end
  end

  assign beat_out = beat_q;
  assign ext_cfg = cfg_q;
  assign ext_valid = ext_valid_q;
  assign dll_running = dll_q;
  assign seq_interleaved = bt_q;
  assign burst_beat_count = bl_q;
  assign bl_bad = bl_bad_q;

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_len_legal: assert property (@(posedge clk) disable iff (rst) // R1
    bl_q == BEATS_4 || bl_q == BEATS_8)
    else $error("burst length not four or eight");
  a_seq_wrap: assert property (@(posedge clk) disable iff (rst) // R4
    ce && state_q == DBX_BURST && bl_q == BEATS_8 && !bt_q &&
    cnt_q == 4'h4 |-> off[2] != start_q[2])
    else $error("eight-beat sequential half not flipped");
  a_il_order: assert property (@(posedge clk) disable iff (rst) // R5
    state_q == DBX_BURST && bl_q == BEATS_8 && bt_q |->
    off == (start_q ^ cnt_q[2:0]))
    else $error("interleaved offset wrong");
  a_four_keep: assert property (@(posedge clk) disable iff (rst) // R3
    state_q == DBX_BURST && bl_q == BEATS_4 |-> off[2] == start_q[2])
    else $error("four-beat burst left its nibble");
  a_no_gap: assert property (@(posedge clk) disable iff (rst) // R6
    ce && state_q == DBX_BURST && last && accept ##1 ce |=>
    beat_q.valid)
    else $error("gap between back-to-back bursts");
  a_no_cross: assert property (@(posedge clk) disable iff (rst) // R8
    ce && state_q == DBX_BURST && !last && accept |->
    bl_q == BEATS_8 && dir_wr_q == is_wr)
    else $error("illegal interruption accepted");
  a_burst_run: assert property (@(posedge clk) disable iff (rst) // R9
    ce && state_q == DBX_BURST && !last && !accept |=>
    state_q == DBX_BURST)
    else $error("burst ended early");
  a_ext_load: assert property (@(posedge clk) disable iff (rst) // R10
    ce && is_load && cmd.bank == BANK_EXT_ONE |=>
    ext_q == $past(cmd.addr) && ext_valid_q)
    else $error("extended load not captured");
  a_sr_off: assert property (@(posedge clk) disable iff (rst) // R14
    ce && sr_entry |=> !dll_q)
    else $error("delay loop still running in self refresh");
  a_dll_bit: assert property (@(posedge clk) disable iff (rst) // R16
    ce && ext_q[EXT_DLL_BIT] |=> !dll_q)
    else $error("delay loop running while disabled");
  c_seamless: cover property (@(posedge clk) disable iff (rst)
    ce && state_q == DBX_BURST && last && accept);
  c_interrupt: cover property (@(posedge clk) disable iff (rst)
    ce && state_q == DBX_BURST && !last && accept);
  c_ext_write: cover property (@(posedge clk) disable iff (rst)
    ce && is_load && cmd.bank == BANK_EXT_ONE);
  c_sr_cycle: cover property (@(posedge clk) disable iff (rst)
    ce && sr_exit && in_sr_q);
endmodule

/* File: hdl/dbx_order.sv */
`timescale 1ns/1ps
// Combinational column order for one beat of a burst
module dbx_order (
  // Burst setup
  input wire logic [2:0] start,
  input wire logic interleaved,
  input wire logic eight,
  // Beat index
  input wire logic [2:0] beat,
  // Resulting low column bits
  output logic [2:0] offset
);
  import dbx_pkg::*;

  // ********************************************************************
  // Ordering
  // ********************************************************************
  logic [1:0] low_seq;
  logic [2:0] seq8;
  // Sequential wraps inside a nibble, so only two bits count
  assign low_seq = start[1:0] + beat[1:0];
  always_comb begin
    seq8 = {start[2] ^ beat[2], low_seq}; // R4
    if (!eight) begin
      // Four-beat bursts keep A2 of the start
      offset = interleaved ? {start[2], start[1:0] ^ beat[1:0]} :
               {start[2], low_seq}; // R3
    end else if (interleaved) begin
      offset = start ^ beat; // R5
    end else begin
      offset = seq8; // R4
    end
  end
endmodule

/* File: hdl/dbx_pkg.sv */
package dbx_pkg;
  // ********************************************************************
  // Command and address encodings
  // ********************************************************************
  // Command codes, taken as {ras_n, cas_n, we_n} with cs_n low
  localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  // Bank selects for the main and first extended register
  localparam logic [2:0] BANK_MAIN = 3'h0;
  localparam logic [2:0] BANK_EXT_ONE = 3'h1;
  localparam int ROW_W = 14;
  localparam int COL_W = 10;

  // ********************************************************************
  // Main register fields
  // ********************************************************************
  localparam int MAIN_BL_LSB = 0;
  localparam int MAIN_BT_BIT = 3;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [3:0] BEATS_4 = 4'h4;
  localparam logic [3:0] BEATS_8 = 4'h8;

  // ********************************************************************
  // First extended register fields
  // ********************************************************************
  localparam int EXT_DLL_BIT = 0;
  localparam int EXT_DRV_BIT = 1;
  localparam int EXT_RTT_LO_BIT = 2;
  localparam int EXT_AL_LSB = 3;
  localparam int EXT_RTT_HI_BIT = 6;
  localparam int EXT_CAL_LSB = 7;
  localparam int EXT_NSTB_BIT = 10;
  localparam int EXT_RSTB_BIT = 11;
  localparam int EXT_QOFF_BIT = 12;
  localparam logic [2:0] AL_RESERVED = 3'h7;
  localparam logic [2:0] CAL_EXIT = 3'h0;
  localparam logic [2:0] CAL_DEFAULT = 3'h7;

  // Termination selections
  typedef enum logic [1:0] {
    DBX_RTT_OFF = 2'h0,
    DBX_RTT_75 = 2'h1,
    DBX_RTT_150 = 2'h2,
    DBX_RTT_50 = 2'h3
  } dbx_rtt_t;

  // Decoded extended configuration
  typedef struct packed {
    logic dll_on;
    logic drive_reduced;
    dbx_rtt_t rtt;
    logic [2:0] added_latency;
    logic al_reserved;
    logic cal_default;
    logic cal_reserved;
    logic read_strobe_copy;
    logic strobe_n_float;
    logic outputs_off;
  } dbx_ext_cfg_t;

  // Command bus as sampled at a rising edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] bank;
    logic [ROW_W-1:0] addr;
  } dbx_cmd_t;

  // Per-beat column output
  typedef struct packed {
    logic valid;
    logic is_write;
    logic [COL_W-1:0] col;
  } dbx_beat_t;
endpackage

/* File: verification/dbx_ctrl_model.sv */
`timescale 1ns/1ps
// ********************************************************************
// Controller model: drives the command bus just after rising edges
// ********************************************************************
module dbx_ctrl_model #(
  parameter int MODE_GAP = 3,
  // Write recovery time and clock period in ns
  parameter int WR_NS = 15,
  parameter int CLK_NS = 8,
  // Set for the narrow part, which has no read strobe copy
  parameter bit NARROW = 1'b0
) (
  // Clock from the bench
  input wire logic clk,
  // Command bus to the device
  output dbx_pkg::dbx_cmd_t cmd,
  output logic cke
);
  import dbx_pkg::*;

  // Write recovery in whole cycles, rounded up
  localparam int WR_CYC = (WR_NS + CLK_NS - 1) / CLK_NS;

  // Deselected with clock enable high from time zero
  initial begin
    cmd = {1'b1, 20'h0};
    cke = 1'b1;
  end

  // One command, taken by the device at the next edge
  task automatic send(input logic [2:0] code, input logic [2:0] bank,
                      input logic [13:0] a);
    cmd <= {1'b0, code, bank, a};
    @(posedge clk);
  endtask

  // Deselect; other lines flip every cycle so stale values never match
  task automatic idle(input int n);
    repeat (n) begin
      cmd <= {1'b1, ~cmd[19:0]};
      @(posedge clk);
    end
  endtask

  // Configuration write while clock enable is high, then the cycle time
  task automatic load(input logic [2:0] bank, input logic [13:0] a);
    logic [13:0] v;
    v = a;
    // Main register always carries the rounded-up write recovery code
    if (bank == BANK_MAIN) begin
      v[11:9] = 3'(WR_CYC - 1);
    end
    // Narrow part keeps the read strobe copy bit clear
    if (NARROW && bank == BANK_EXT_ONE) begin
      v[EXT_RSTB_BIT] = 1'b0;
    end
    send(CMD_LOAD_MODE, bank, v);
    idle(MODE_GAP);
  endtask

  // Self refresh entry: refresh code with clock enable falling
  task automatic enter();
    cke <= 1'b0;
    send(CMD_REFRESH, 3'h0, 14'h0);
  endtask

  // Self refresh exit: clock enable back high while deselected
  task automatic leave();
    cke <= 1'b1;
    idle(MODE_GAP);
  endtask
endmodule

/* File: verification/ddr2_burst_order_and_ext_mode_decode_tb.sv */
`timescale 1ns/1ps
// ********************************************************************
// Bench: config decode, burst order, interruption, self refresh
// ********************************************************************
module ddr2_burst_order_and_ext_mode_decode_tb;
  import dbx_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  dbx_cmd_t cmd;
  logic cke;
  dbx_beat_t beat_out;
  dbx_ext_cfg_t ext_cfg;
  logic ext_valid, dll_running, seq_interleaved, bl_bad;
  logic [3:0] burst_beat_count;
  // Bookkeeping
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int first = -1;
  int last = 0;
  logic cur_il;
  int cur_n;
  // Expected beats as {is_write, col}
  logic [10:0] q[$];
  // Extended values: reserved codes only probe the flags; the table
  // ends on legal codes, which stay in force for the bursts
  logic [13:0] ext_tab[7] = '{14'h1FFF, 14'h0382, 14'h00BA, 14'h0C44,
                              14'h0070, 14'h0004, 14'h0000};

  // 8 ns period
  always #4 clk = ~clk;

  dbx_core u_dut (.clk(clk), .rst(rst), .ce(ce), .cmd(cmd), .cke(cke),
    .beat_out(beat_out), .ext_cfg(ext_cfg), .ext_valid(ext_valid),
    .dll_running(dll_running), .seq_interleaved(seq_interleaved),
    .burst_beat_count(burst_beat_count), .bl_bad(bl_bad));

  dbx_ctrl_model u_ctrl (.clk(clk), .cmd(cmd), .cke(cke));

  // Verdict and end of run
  task automatic stop_test();
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Counted comparison
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  // Column offset of beat i, worked out independently of the design
  function automatic logic [2:0] ord(input logic [2:0] s, input logic il,
                                     input logic e8, input int i);
    logic [2:0] b;
    b = 3'(i);
    if (il) begin
      return e8 ? s ^ b : {s[2], s[1:0] ^ b[1:0]};
    end
    return {e8 ? s[2] ^ b[2] : s[2], s[1:0] + b[1:0]};
  endfunction

  // Expected decode of the extended register
  function automatic dbx_ext_cfg_t exp_cfg(input logic [13:0] a);
    dbx_ext_cfg_t e;
    e.dll_on = ~a[0];
    e.drive_reduced = a[1];
    e.rtt = dbx_rtt_t'({a[6], a[2]});
    e.added_latency = a[5:3];
    e.al_reserved = (a[5:3] == AL_RESERVED);
    e.cal_default = (a[9:7] == CAL_DEFAULT);
    e.cal_reserved = (a[9:7] != CAL_EXIT) && (a[9:7] != CAL_DEFAULT);
    e.read_strobe_copy = a[11];
    e.strobe_n_float = a[10];
    e.outputs_off = a[12];
    return e;
  endfunction

  // Queue keep beats of a burst, then issue it
  task automatic burst(input logic wr, input logic [2:0] s, input int keep);
    logic [6:0] hi;
    hi = 7'(s * 9 + 3);
    for (int i = 0; i < keep; i++) begin
      q.push_back({wr, hi, ord(s, cur_il, cur_n == 8, i)});
    end
    u_ctrl.send(wr ? CMD_WRITE : CMD_READ, 3'h0, {4'h0, hi, s});
  endtask

  // Beat monitor and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      stop_test();
    end
    if (beat_out.valid === 1'b1) begin
      if (first < 0) begin
        first = cyc;
      end
      last = cyc;
      chk(q.size() > 0 && {beat_out.is_write, beat_out.col} === q[0],
          "beat order");
      if (q.size() > 0) begin
        void'(q.pop_front());
      end
    end
  end

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    u_ctrl.idle(3);
    chk(burst_beat_count === BEATS_4 && ext_valid === 1'b0, "reset");
    chk(dll_running === 1'b0, "loop before config");
    foreach (ext_tab[k]) begin
      u_ctrl.load(BANK_EXT_ONE, ext_tab[k]);
      chk(ext_cfg === exp_cfg(ext_tab[k]), "ext decode");
      chk(dll_running === ~ext_tab[k][0], "loop enable");
    end
    chk(ext_valid === 1'b1, "ext written");
    u_ctrl.idle(200);
    // Every order, length and start, bursts back to back
    for (int bt = 0; bt < 2; bt++) begin
      for (int e8 = 0; e8 < 2; e8++) begin
        cur_il = bt[0];
        cur_n = e8 ? 8 : 4;
        u_ctrl.load(BANK_MAIN, {10'h0, cur_il, e8 ? BL_CODE_8 : BL_CODE_4});
        chk(seq_interleaved === cur_il && burst_beat_count ===
            (e8 ? BEATS_8 : BEATS_4), "main");
        first = -1;
        for (int s = 0; s < 8; s++) begin
          burst(cur_il, 3'(s), cur_n);
          u_ctrl.idle(cur_n - 1);
        end
        u_ctrl.idle(4);
        chk(last - first === 8 * cur_n - 1 && q.size() === 0, "gap");
      end
    end
    // Eight-beat interleaved: read cut by read, read not cut by write
    burst(1'b0, 3'h0, 2);
    u_ctrl.idle(1);
    burst(1'b0, 3'h4, 8);
    u_ctrl.idle(7);
    burst(1'b0, 3'h0, 8);
    u_ctrl.idle(1);
    u_ctrl.send(CMD_WRITE, 3'h0, 14'h0);
    u_ctrl.idle(12);
    chk(q.size() === 0, "interrupted bursts");
    // Illegal length code keeps the length
    u_ctrl.load(BANK_MAIN, 14'h0005);
    chk(bl_bad === 1'b1 && burst_beat_count === BEATS_8, "bad len");
    u_ctrl.load(BANK_MAIN, {11'h0, BL_CODE_4});
    chk(bl_bad === 1'b0 && burst_beat_count === BEATS_4, "len 4");
    // Enable ce low freezes state: a load in that window is lost
    ce <= 1'b0;
    u_ctrl.load(BANK_MAIN, {10'h0, 1'b1, BL_CODE_8});
    ce <= 1'b1;
    u_ctrl.idle(1);
    chk(burst_beat_count === BEATS_4 && seq_interleaved === 1'b0,
        "frozen");
    // Self refresh stops and restarts the loop
    u_ctrl.enter();
    u_ctrl.idle(4);
    chk(dll_running === 1'b0, "loop off in self refresh");
    u_ctrl.leave();
    u_ctrl.idle(2);
    chk(dll_running === 1'b1, "loop back on");
    stop_test();
  end
endmodule
